// ==== src/pofr_cfg.svh ====
// constants for the on/off and fault response command registers
`ifndef POFR_CFG_SVH
`define POFR_CFG_SVH

// command codes
`define POFR_CMD_RUN         8'h01
`define POFR_CMD_GATING      8'h02
`define POFR_CMD_CLEAR       8'h03
`define POFR_CMD_RESTORE     8'h12
`define POFR_CMD_STORE       8'h15
`define POFR_CMD_OV_LIMIT    8'h40
`define POFR_CMD_OV_RESP     8'h41
`define POFR_CMD_OC_LIMIT    8'h46
`define POFR_CMD_OC_RESP     8'h47
`define POFR_CMD_OT_LIMIT    8'h4f
`define POFR_CMD_FW_REV      8'h9b

// run control fields
`define POFR_RUN_ON_BIT      7
`define POFR_RUN_SEL_HI      5
`define POFR_RUN_SEL_LO      4
`define POFR_RUN_RESET       8'h80
`define POFR_SEL_NOMINAL     2'h0
`define POFR_SEL_MARGIN_LO   2'h1
`define POFR_SEL_MARGIN_HI   2'h2
`define POFR_SEL_BAD         2'h3

// power-up gating configuration, fixed: combined and command gating set
`define POFR_GATING_VALUE    8'h18

// response register fields
`define POFR_RESP_CODE_HI    7
`define POFR_RESP_CODE_LO    6
`define POFR_RETRY_HI        5
`define POFR_RETRY_LO        3
`define POFR_RESP_MASK       8'hf8
`define POFR_OV_RESP_CODE    2'h2
`define POFR_OC_RESP_CODE    2'h3
`define POFR_RETRY_LATCH     3'h0
`define POFR_RETRY_FOREVER   3'h7
`define POFR_OV_RESP_RESET   8'h80
`define POFR_OC_RESP_RESET   8'hf8

// limits: output voltage in linear16 with exponent -10, others linear11 exponent 0
`define POFR_OV_LOW          16'h34cd
`define POFR_OV_HIGH         16'h3800
`define POFR_OV_RESET        16'h3600
`define POFR_OC_LOW          16'h002b
`define POFR_OC_HIGH         16'h0050
`define POFR_OC_RESET        16'h004b
`define POFR_OT_LOW          16'h0078
`define POFR_OT_HIGH         16'h008c
`define POFR_OT_RESET        16'h0087

// read lengths in bytes: firmware revision block, word registers, byte registers
`define POFR_FW_COUNT        2'h2
`define POFR_WORD_COUNT      2'h2
`define POFR_BYTE_COUNT      2'h1

`endif

// ==== src/pofr_pkg.sv ====
// types shared by the on/off and fault response command registers
package pofr_pkg;

  // one command from the bus front end, valid for one cycle
  typedef struct packed {
    logic        valid;  // command present this cycle
    logic        write;  // 1 write, 0 read
    logic [7:0]  code;   // command code
    logic [15:0] data;   // write data, bytes in low bits
  } pofr_cmd_t;

  // answer to a command, valid for one cycle
  typedef struct packed {
    logic        valid;  // answer present
    logic        ack;    // 1 command known, 0 refused
    logic [1:0]  count;  // bytes returned
    logic [15:0] data;   // read data
  } pofr_rsp_t;

  // sticky fault flags
  typedef struct packed {
    logic ot;
    logic oc;
    logic ov;
  } pofr_faults_t;

  // fault response sequencer states
  typedef enum logic [1:0] {
    POFR_ARMED,
    POFR_LATCHED,
    POFR_WAITING
  } pofr_state_t;

endpackage

// ==== src/pofr_limit_clamp.sv ====
// one protection limit register with range clamping
`timescale 1ns/1ps
`include "pofr_cfg.svh"
module pofr_limit_clamp #(
  parameter logic [15:0] LOW      = 16'h0000, // lower bound code
  parameter logic [15:0] HIGH     = 16'hffff, // upper bound code
  parameter logic [15:0] RESETVAL = 16'h0000, // value after reset
  parameter bit          LINEAR11 = 1'b1      // exponent in bits 15:11
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  output logic [15:0]      limit
);
  logic inRange; // write lies within the permitted window

  // linear11 writes must carry the exponent of the lower bound LOW; the mantissa is then compared
  always_comb begin
    if (LINEAR11) begin
      inRange = (wrData[15:11] == LOW[15:11]) &&
                ($signed(wrData[10:0]) >= $signed(LOW[10:0])) &&
                ($signed(wrData[10:0]) <= $signed(HIGH[10:0]));
    end else begin
      inRange = (wrData >= LOW) && (wrData <= HIGH);
    end
  end

  // a value outside the window falls back to the lower bound, not the old value
  always_ff @(posedge clk) begin
    if (rst) begin
      limit <= RESETVAL;
    end else if (wrEn) begin
      limit <= inRange ? wrData : LOW;
    end
  end
endmodule

// ==== src/pofr_fault_resp.sv ====
// response register and shutdown sequencer for one fault source
`timescale 1ns/1ps
`include "pofr_cfg.svh"
module pofr_fault_resp
  import pofr_pkg::*;
#(
  parameter logic [1:0] CODE         = 2'h2,  // only supported response code
  parameter logic [7:0] RESETVAL     = 8'h80, // response value after reset
  parameter int         RETRY_CYCLES = 256    // wait before each restart
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fault,
  input  wire logic       runOn,
  input  wire logic       runWrite,
  input  wire logic       wrEn,
  input  wire logic [7:0] wrData,
  output logic [7:0]      resp,
  output logic            tripped
);
  import pofr_pkg::*;

  pofr_state_t  state;    // sequencer state
  logic [15:0]  waitCnt;  // restart wait counter
  logic [2:0]   retry;    // stored retry field
  logic         wrValid;  // write carries supported codes

  assign retry = resp[`POFR_RETRY_HI:`POFR_RETRY_LO];
  assign wrValid = (wrData[`POFR_RESP_CODE_HI:`POFR_RESP_CODE_LO] == CODE) &&
                   ((wrData[`POFR_RETRY_HI:`POFR_RETRY_LO] == `POFR_RETRY_LATCH) ||
                    (wrData[`POFR_RETRY_HI:`POFR_RETRY_LO] == `POFR_RETRY_FOREVER));
  assign tripped = (state != POFR_ARMED);

  // register keeps its old value on unsupported writes; delay bits stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      resp <= RESETVAL;
    end else if (wrEn && wrValid) begin
      resp <= wrData & `POFR_RESP_MASK;
    end
  end

  // shut down on fault, then latch or retry as the retry field says
  always_ff @(posedge clk) begin
    if (rst) begin
      state   <= POFR_ARMED;
      waitCnt <= 16'h0000;
    end else begin
      case (state)
        POFR_ARMED: begin
          waitCnt <= 16'h0000;
          if (fault && runOn) begin
            state <= (retry == `POFR_RETRY_LATCH) ? POFR_LATCHED : POFR_WAITING;
          end
        end
        POFR_LATCHED: begin
          if (runWrite) begin
            state <= POFR_ARMED;
          end
        end
        POFR_WAITING: begin
          if (!runOn) begin // commanded off ends retrying
            state <= POFR_ARMED;
          end else if (waitCnt >= 16'(RETRY_CYCLES - 1)) begin
            state <= POFR_ARMED; // restart attempt
          end else begin
            waitCnt <= waitCnt + 16'h0001;
          end
        end
        default: begin
          state <= POFR_ARMED;
        end
      endcase
    end
  end
endmodule

// ==== src/pofr_regs.sv ====
// command register bank: on/off control, gating, limits and fault response
`timescale 1ns/1ps
`include "pofr_cfg.svh"
module pofr_regs
  import pofr_pkg::*;
#(
  parameter int          RETRY_CYCLES = 256,     // restart wait in clock cycles
  parameter logic [15:0] FW_REV       = 16'h3130 // arbitrary firmware revision bytes
) (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire pofr_pkg::pofr_cmd_t   cmdIn,
  output pofr_pkg::pofr_rsp_t        rspOut,
  input  wire logic                  controlPin,
  input  wire logic                  ovFaultPin,
  input  wire logic                  ocFaultPin,
  input  wire logic                  otFaultPin,
  output logic                       powerOn,
  output logic [1:0]                 setpointSel,
  output pofr_pkg::pofr_faults_t     faultFlags,
  output logic                       nvmLockout
);
  import pofr_pkg::*;

  // synchronisers for pins from the analog side
  logic [1:0]   ctlSync;     // control pin, stage 0 then 1
  logic [1:0]   ovSync;      // over-voltage comparator
  logic [1:0]   ocSync;      // over-current comparator
  logic [1:0]   otSync;      // over-temperature comparator
  logic         ctlOn;       // synchronised control pin
  logic         ovFault;     // synchronised over-voltage fault
  logic         ocFault;     // synchronised over-current fault
  logic         otFault;     // synchronised over-temperature fault

  // run control register contents
  logic         runOn;       // output commanded on
  logic [1:0]   runSel;      // setpoint source

  // command decode
  logic         isWrite;     // write command this cycle
  logic         isRead;      // read command this cycle
  logic         runWrite;    // run control written
  logic         ovLimWr;     // over-voltage limit write
  logic         ocLimWr;     // over-current limit write
  logic         otLimWr;     // over-temperature limit write
  logic         ovRespWr;    // over-voltage response write
  logic         ocRespWr;    // over-current response write
  logic         clearCmd;    // clear-faults command
  logic         nvmAccess;   // store or restore touched

  // stored values
  logic [15:0]  ovLimit;     // over-voltage limit
  logic [15:0]  ocLimit;     // over-current limit
  logic [15:0]  otLimit;     // over-temperature limit
  logic [7:0]   ovResp;      // over-voltage response
  logic [7:0]   ocResp;      // over-current response
  logic         ovTripped;   // over-voltage sequencer holds output off
  logic         ocTripped;   // over-current sequencer holds output off

  // remote off-on tracking
  logic         pinWasOff;   // control pin seen off since last clear
  logic         runWasOff;   // run bit seen off since last clear
  logic         cycleClear;  // off-then-on cycle completed
  logic         next_powerOn;
  pofr_rsp_t    next_rsp;

  // two flip-flops per pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (rst) begin
      ctlSync <= 2'h0;
      ovSync  <= 2'h0;
      ocSync  <= 2'h0;
      otSync  <= 2'h0;
    end else begin
      ctlSync <= {ctlSync[0], controlPin};
      ovSync  <= {ovSync[0], ovFaultPin};
      ocSync  <= {ocSync[0], ocFaultPin};
      otSync  <= {otSync[0], otFaultPin};
    end
  end

  assign ctlOn   = ctlSync[1];
  assign ovFault = ovSync[1];
  assign ocFault = ocSync[1];
  assign otFault = otSync[1];

  // command decode, one cycle per command
  assign isWrite   = cmdIn.valid && cmdIn.write;
  assign isRead    = cmdIn.valid && !cmdIn.write;
  assign runWrite  = isWrite && (cmdIn.code == `POFR_CMD_RUN);
  assign ovLimWr   = isWrite && (cmdIn.code == `POFR_CMD_OV_LIMIT);
  assign ocLimWr   = isWrite && (cmdIn.code == `POFR_CMD_OC_LIMIT);
  assign otLimWr   = isWrite && (cmdIn.code == `POFR_CMD_OT_LIMIT);
  assign ovRespWr  = isWrite && (cmdIn.code == `POFR_CMD_OV_RESP);
  assign ocRespWr  = isWrite && (cmdIn.code == `POFR_CMD_OC_RESP);
  assign clearCmd  = isWrite && (cmdIn.code == `POFR_CMD_CLEAR);
  // a read counts as an access too, so any direction locks the output
  assign nvmAccess = cmdIn.valid &&
                     ((cmdIn.code == `POFR_CMD_STORE) ||
                      (cmdIn.code == `POFR_CMD_RESTORE));

  // on/off bit follows every run control write
  always_ff @(posedge clk) begin
    if (rst) begin
      runOn <= 1'(`POFR_RUN_RESET >> `POFR_RUN_ON_BIT);
    end else if (runWrite) begin
      runOn <= cmdIn.data[`POFR_RUN_ON_BIT];
    end
  end

  // setpoint source; the unsupported code leaves the field as it was
  always_ff @(posedge clk) begin
    if (rst) begin
      runSel <= `POFR_SEL_NOMINAL;
    end else if (runWrite &&
                 (cmdIn.data[`POFR_RUN_SEL_HI:`POFR_RUN_SEL_LO] != `POFR_SEL_BAD)) begin
      runSel <= cmdIn.data[`POFR_RUN_SEL_HI:`POFR_RUN_SEL_LO];
    end
  end

  // setpoint selection drives the reference mux of the power stage
  always_ff @(posedge clk) begin
    if (rst) begin
      setpointSel <= `POFR_SEL_NOMINAL;
    end else begin
      setpointSel <= runSel;
    end
  end

  // store/restore lockout only ends with input power, i.e. reset
  always_ff @(posedge clk) begin
    if (rst) begin
      nvmLockout <= 1'b0;
    end else if (nvmAccess) begin
      nvmLockout <= 1'b1;
    end
  end

  // protection limits with clamping
  pofr_limit_clamp #(
    .LOW      (`POFR_OV_LOW),
    .HIGH     (`POFR_OV_HIGH),
    .RESETVAL (`POFR_OV_RESET),
    .LINEAR11 (1'b0)
  ) ovLimitReg (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (ovLimWr),
    .wrData (cmdIn.data),
    .limit  (ovLimit)
  );

  pofr_limit_clamp #(
    .LOW      (`POFR_OC_LOW),
    .HIGH     (`POFR_OC_HIGH),
    .RESETVAL (`POFR_OC_RESET),
    .LINEAR11 (1'b1)
  ) ocLimitReg (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (ocLimWr),
    .wrData (cmdIn.data),
    .limit  (ocLimit)
  );

  pofr_limit_clamp #(
    .LOW      (`POFR_OT_LOW),
    .HIGH     (`POFR_OT_HIGH),
    .RESETVAL (`POFR_OT_RESET),
    .LINEAR11 (1'b1)
  ) otLimitReg (
    .clk    (clk),
    .rst    (rst),
    .wrEn   (otLimWr),
    .wrData (cmdIn.data),
    .limit  (otLimit)
  );

  // fault sequencers; over-temperature response is handled elsewhere
  pofr_fault_resp #(
    .CODE         (`POFR_OV_RESP_CODE),
    .RESETVAL     (`POFR_OV_RESP_RESET),
    .RETRY_CYCLES (RETRY_CYCLES)
  ) ovResponse (
    .clk      (clk),
    .rst      (rst),
    .fault    (ovFault),
    .runOn    (runOn),
    .runWrite (runWrite),
    .wrEn     (ovRespWr),
    .wrData   (cmdIn.data[7:0]),
    .resp     (ovResp),
    .tripped  (ovTripped)
  );

  pofr_fault_resp #(
    .CODE         (`POFR_OC_RESP_CODE),
    .RESETVAL     (`POFR_OC_RESP_RESET),
    .RETRY_CYCLES (RETRY_CYCLES)
  ) ocResponse (
    .clk      (clk),
    .rst      (rst),
    .fault    (ocFault),
    .runOn    (runOn),
    .runWrite (runWrite),
    .wrEn     (ocRespWr),
    .wrData   (cmdIn.data[7:0]),
    .resp     (ocResp),
    .tripped  (ocTripped)
  );

  // remember an off phase of pin or run bit; the following on completes a cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      pinWasOff <= 1'b0;
      runWasOff <= 1'b0;
    end else begin
      if (!ctlOn) begin
        pinWasOff <= 1'b1;
      end else if (cycleClear) begin
        pinWasOff <= 1'b0;
      end
      if (!runOn) begin
        runWasOff <= 1'b1;
      end else if (cycleClear) begin
        runWasOff <= 1'b0;
      end
    end
  end

  assign cycleClear = (pinWasOff && ctlOn) || (runWasOff && runOn);

  // sticky fault flags; a fault in the clearing cycle still sets its flag
  always_ff @(posedge clk) begin
    if (rst) begin
      faultFlags <= '0;
    end else begin
      faultFlags.ov <= ovFault || (faultFlags.ov && !(clearCmd || cycleClear));
      faultFlags.oc <= ocFault || (faultFlags.oc && !(clearCmd || cycleClear));
      faultFlags.ot <= otFault || (faultFlags.ot && !(clearCmd || cycleClear));
    end
  end

  // power up needs both the pin and the command; pin alone never suffices
  always_comb begin
    next_powerOn = runOn && ctlOn;
    if (nvmLockout || nvmAccess) begin
      next_powerOn = 1'b0;
    end
    if (ovTripped || ocTripped) begin
      next_powerOn = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      powerOn <= 1'b0;
    end else begin
      powerOn <= next_powerOn;
    end
  end

  // read data and acknowledge; unknown codes answer with ack low
  always_comb begin
    next_rsp       = '0;
    next_rsp.valid = cmdIn.valid;
    if (isRead) begin
      case (cmdIn.code)
        `POFR_CMD_RUN: begin
          next_rsp.ack   = 1'b1;
          next_rsp.count = `POFR_BYTE_COUNT;
          next_rsp.data  = {8'h00, runOn, 1'b0, runSel, 4'h0};
        end
        `POFR_CMD_GATING: begin
          next_rsp.ack   = 1'b1;
          next_rsp.count = `POFR_BYTE_COUNT;
          next_rsp.data  = {8'h00, `POFR_GATING_VALUE};
        end
        `POFR_CMD_OV_LIMIT: begin
          next_rsp.ack   = 1'b1;
          next_rsp.count = `POFR_WORD_COUNT;
          next_rsp.data  = ovLimit;
        end
        `POFR_CMD_OV_RESP: begin
          next_rsp.ack   = 1'b1;
          next_rsp.count = `POFR_BYTE_COUNT;
          next_rsp.data  = {8'h00, ovResp};
        end
        `POFR_CMD_OC_LIMIT: begin
          next_rsp.ack   = 1'b1;
          next_rsp.count = `POFR_WORD_COUNT;
          next_rsp.data  = ocLimit;
        end
        `POFR_CMD_OC_RESP: begin
          next_rsp.ack   = 1'b1;
          next_rsp.count = `POFR_BYTE_COUNT;
          next_rsp.data  = {8'h00, ocResp};
        end
        `POFR_CMD_OT_LIMIT: begin
          next_rsp.ack   = 1'b1;
          next_rsp.count = `POFR_WORD_COUNT;
          next_rsp.data  = otLimit;
        end
        `POFR_CMD_FW_REV: begin
          next_rsp.ack   = 1'b1;
          next_rsp.count = `POFR_FW_COUNT;
          next_rsp.data  = FW_REV;
        end
        `POFR_CMD_STORE, `POFR_CMD_RESTORE: begin
          next_rsp.ack = 1'b1; // accepted, output now locked
        end
        default: begin
          next_rsp.ack = 1'b0; // unmapped or write-only code
        end
      endcase
    end else if (isWrite) begin
      case (cmdIn.code)
        `POFR_CMD_RUN, `POFR_CMD_CLEAR, `POFR_CMD_STORE, `POFR_CMD_RESTORE,
        `POFR_CMD_OV_LIMIT, `POFR_CMD_OV_RESP, `POFR_CMD_OC_LIMIT,
        `POFR_CMD_OC_RESP, `POFR_CMD_OT_LIMIT: begin
          next_rsp.ack = 1'b1;
        end
        default: begin
          next_rsp.ack = 1'b0; // read-only (gating included) or unknown
        end
      endcase
    end
  end

  // answer one cycle after the command
  always_ff @(posedge clk) begin
    if (rst) begin
      rspOut <= '0;
    end else begin
      rspOut <= next_rsp;
    end
  end
endmodule

// ==== verification/pofr_regs_properties.sv ====
// concurrent checks on the ports of the command register bank
`timescale 1ns/1ps
module pofr_regs_properties (
  input wire logic                clk,
  input wire logic                rst,
  input wire pofr_pkg::pofr_cmd_t cmdIn,
  input wire pofr_pkg::pofr_rsp_t rspOut,
  input wire logic                controlPin,
  input wire logic                ovFaultPin,
  input wire logic                ocFaultPin,
  input wire logic                otFaultPin,
  input wire logic                powerOn,
  input wire logic [1:0]          setpointSel,
  input wire pofr_pkg::pofr_faults_t faultFlags,
  input wire logic                nvmLockout
);
  import pofr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a run write whose setpoint code is a supported one
  sequence selWrite;
    cmdIn.valid && cmdIn.write && cmdIn.code == 8'h01 && cmdIn.data[5:4] != 2'h3;
  endsequence
  // a read of one command code
  sequence readOf(logic [7:0] c);
    cmdIn.valid && !cmdIn.write && cmdIn.code == c;
  endsequence
  // fault pins low long enough that the sync pipe holds nothing
  sequence pinsQuiet;
    !(ovFaultPin || ocFaultPin || otFaultPin) [*4];
  endsequence
  run_off_a:
    assert property (cmdIn.valid && cmdIn.write && cmdIn.code == 8'h01 && !cmdIn.data[7]
      |-> ##2 !powerOn) else $error("output stayed on after run bit cleared");
  sel_follow_a:
    assert property (selWrite |-> ##2 setpointSel == $past(cmdIn.data[5:4], 2))
      else $error("setpoint source does not follow run write");
  sel_legal_a:
    assert property (setpointSel != 2'h3) else $error("unsupported setpoint source seen");
  gating_read_a:
    assert property (readOf(8'h02) |=> rspOut.ack && rspOut.data == 16'h0018)
      else $error("gating configuration read wrong");
  ov_trip_a:
    assert property ($rose(ovFaultPin) ##1 ovFaultPin [*3] |=> !powerOn)
      else $error("output still on after over-voltage fault");
  flag_sticky_a:
    assert property ((controlPin && !cmdIn.valid) [*4] ##0 faultFlags.ov |=> faultFlags.ov)
      else $error("fault flag dropped without a clearing event");
  clear_flags_a:
    assert property (pinsQuiet ##0 (cmdIn.valid && cmdIn.write && cmdIn.code == 8'h03)
      |=> faultFlags == '0) else $error("clear command left flags set");
  lockout_set_a:
    assert property (cmdIn.valid && (cmdIn.code == 8'h12 || cmdIn.code == 8'h15)
      |=> nvmLockout) else $error("store access did not lock output");
  lockout_hold_a:
    assert property (nvmLockout |-> !powerOn ##1 nvmLockout)
      else $error("lockout released or output on");
  fw_count_a:
    assert property (readOf(8'h9b) |=> rspOut.ack && rspOut.count == 2'h2)
      else $error("revision block count wrong");
  resp_zero_a:
    assert property (readOf(8'h41) or readOf(8'h47)
      |=> rspOut.data[2:0] == 3'h0 && rspOut.data[15:8] == 8'h00)
      else $error("reserved response bits not zero");
endmodule
bind pofr_regs pofr_regs_properties chk (.clk(clk), .rst(rst), .cmdIn(cmdIn),
  .rspOut(rspOut), .controlPin(controlPin), .ovFaultPin(ovFaultPin),
  .ocFaultPin(ocFaultPin), .otFaultPin(otFaultPin), .powerOn(powerOn),
  .setpointSel(setpointSel), .faultFlags(faultFlags), .nvmLockout(nvmLockout));

// ==== verification/pofr_host.sv ====
// host controller model that issues commands to the register bank
`timescale 1ns/1ps
module pofr_host (
  input  wire logic                clk,
  output pofr_pkg::pofr_cmd_t      cmd,
  input  wire pofr_pkg::pofr_rsp_t rsp
);
  import pofr_pkg::*;
  // idle lines
  initial cmd = '0;
  // drive after a falling edge, taken at the next rise, answer stands one cycle
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output pofr_rsp_t r);
    @(negedge clk);
    cmd = '{1'b1, w, c, d};
    @(negedge clk);
    r = rsp;
    // released lines show the inverse so stale values cannot pass
    cmd = '{1'b0, ~w, ~c, ~d};
  endtask
  // new limit keeps the exponent read back from the register
  function automatic logic [15:0] keep_exp(input logic [15:0] old, input logic [15:0] m);
    return {old[15:11], m[10:0]};
  endfunction
endmodule

// ==== verification/pofr_regs_tb_top.sv ====
// self-checking bench for the command register bank
`timescale 1ns/1ps
`include "pofr_cfg.svh"
module pofr_regs_tb_top;
  import pofr_pkg::*;
  localparam logic [15:0] FW = 16'h5a17; // arbitrary revision bytes
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         controlPin = 1'b0, ovPin = 1'b0, ocPin = 1'b0, otPin = 1'b0;
  pofr_cmd_t    cmd;
  pofr_rsp_t    rsp, got, exp;
  logic         powerOn, nvmLockout;
  logic [1:0]   sel;
  pofr_faults_t flags;
  int           failures = 0, total_checks = 0;
  logic [31:0]  seed = 32'h0000_43de;
  // reference register contents
  logic [7:0]   mRun = 8'h80, mOvR = `POFR_OV_RESP_RESET, mOcR = `POFR_OC_RESP_RESET;
  logic [15:0]  mOv = `POFR_OV_RESET, mOc = `POFR_OC_RESET, mOt = `POFR_OT_RESET;
  logic [7:0]   codes [10] = '{8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h46, 8'h47, 8'h4f,
                               8'h9b, 8'h77};
  logic [7:0]   lc [3] = '{8'h40, 8'h46, 8'h4f};
  logic [15:0]  ll [3] = '{`POFR_OV_LOW, `POFR_OC_LOW, `POFR_OT_LOW};
  logic [15:0]  lh [3] = '{`POFR_OV_HIGH, `POFR_OC_HIGH, `POFR_OT_HIGH};
  // free-running clock, short retry wait to keep the run brief
  always #2 clk = ~clk;
  pofr_regs #(.RETRY_CYCLES(8), .FW_REV(FW)) dut (.clk(clk), .rst(rst), .cmdIn(cmd),
    .rspOut(rsp), .controlPin(controlPin), .ovFaultPin(ovPin), .ocFaultPin(ocPin),
    .otFaultPin(otPin), .powerOn(powerOn), .setpointSel(sel), .faultFlags(flags),
    .nvmLockout(nvmLockout));
  pofr_host host (.clk(clk), .cmd(cmd), .rsp(rsp));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // out of window, or another exponent on linear11, stores the lower bound
  function automatic logic [15:0] clamp(input logic [15:0] d, lo, hi, input bit l11);
    return ((l11 && d[15:11] != 5'h0) || d < lo || d > hi) ? lo : d;
  endfunction
  function automatic bit respOk(input logic [7:0] d, input logic [1:0] code);
    return d[7:6] == code && (d[5:3] == 3'h0 || d[5:3] == 3'h7);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  // reference answer, and register update for writes
  task automatic model(input logic w, input logic [7:0] c, input logic [15:0] d);
    exp = '0;
    exp.valid = 1'b1;
    exp.ack = 1'b1;
    if (w) begin
      case (c)
        8'h01: begin
          mRun[7] = d[7];
          if (d[5:4] != 2'h3) mRun[5:4] = d[5:4];
        end
        8'h03, 8'h12, 8'h15: ;
        8'h40: mOv = clamp(d, `POFR_OV_LOW, `POFR_OV_HIGH, 1'b0);
        8'h41: if (respOk(d[7:0], 2'h2)) mOvR = d[7:0] & 8'hf8;
        8'h46: mOc = clamp(d, `POFR_OC_LOW, `POFR_OC_HIGH, 1'b1);
        8'h47: if (respOk(d[7:0], 2'h3)) mOcR = d[7:0] & 8'hf8;
        8'h4f: mOt = clamp(d, `POFR_OT_LOW, `POFR_OT_HIGH, 1'b1);
        default: exp.ack = 1'b0;
      endcase
    end else begin
      exp.count = (c == 8'h40 || c == 8'h46 || c == 8'h4f || c == 8'h9b) ? 2'h2 : 2'h1;
      case (c)
        8'h01: exp.data = {8'h00, mRun[7], 1'b0, mRun[5:4], 4'h0};
        8'h02: exp.data = 16'h0018;
        8'h40: exp.data = mOv;
        8'h41: exp.data = {8'h00, mOvR};
        8'h46: exp.data = mOc;
        8'h47: exp.data = {8'h00, mOcR};
        8'h4f: exp.data = mOt;
        8'h9b: exp.data = FW;
        default: begin
          exp.ack = 1'b0;
          exp.count = 2'h0;
        end
      endcase
    end
  endtask
  // one command through the host, compared with the reference
  task automatic send(input logic w, input logic [7:0] c, input logic [15:0] d);
    host.xfer(w, c, d, got);
    model(w, c, d);
    check({14'h0, got.valid, got.ack}, {14'h0, exp.valid, exp.ack});
    check({14'h0, got.count}, {14'h0, exp.count});
    check(got.data, exp.data);
  endtask
  // levels as {lockout, on, ot, oc, ov} after n falling edges, plus setpoint source
  task automatic look(input int n, input logic [4:0] want);
    repeat (n) @(negedge clk);
    check({11'h0, nvmLockout, powerOn, flags}, {11'h0, want});
    check({14'h0, sel}, {14'h0, mRun[5:4]});
  endtask
  task automatic pulse(ref logic pin);
    pin = 1'b1;
    repeat (6) @(negedge clk);
    pin = 1'b0;
  endtask
  task automatic complete_run;
    $display("checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #40000;
    failures++;
    complete_run;
  end
  initial begin
    logic [7:0]  c;
    logic [15:0] d;
    repeat (12) @(negedge clk);
    look(0, 5'b00000);
    rst = 1'b0;
    foreach (codes[i]) send(1'b0, codes[i], 16'h0000);
    // limit boundaries: one below, both ends, one above
    foreach (lc[i]) for (int k = 0; k < 4; k++) begin
      send(1'b1, lc[i], k < 2 ? 16'(ll[i] + k - 1) : 16'(lh[i] + k - 2));
      send(1'b0, lc[i], 16'h0000);
    end
    // random traffic over every code except store and restore, refusals included
    for (int n = 0; n < 80; n++) begin
      seed = xorshift(seed);
      c = codes[seed[31:24] % 10];
      d = seed[15:0];
      if (c == 8'h41 || c == 8'h47) d[5:3] = seed[16] ? 3'h7 : (seed[17] ? 3'h0 : d[5:3]);
      if ((c == 8'h46 || c == 8'h4f) && seed[18]) begin
        send(1'b0, c, 16'h0000);
        d = host.keep_exp(got.data, {8'h00, seed[7:0]});
      end
      send(seed[19], c, d);
    end
    send(1'b1, 8'h41, 16'h0080);
    send(1'b1, 8'h47, 16'h00f8);
    send(1'b1, 8'h01, 16'h00a0);
    controlPin = 1'b1;
    look(5, 5'b01000);
    send(1'b1, 8'h01, 16'h0000);
    look(1, 5'b00000);
    send(1'b1, 8'h01, 16'h0080);
    controlPin = 1'b0;
    look(5, 5'b00000);
    controlPin = 1'b1;
    look(5, 5'b01000);
    pulse(ovPin);
    look(20, 5'b00001);
    send(1'b1, 8'h01, 16'h00b0);
    look(2, 5'b01001);
    send(1'b1, 8'h03, 16'h0000);
    look(2, 5'b01000);
    pulse(ocPin);
    look(1, 5'b00010);
    look(25, 5'b01010);
    send(1'b1, 8'h03, 16'h0000);
    pulse(otPin);
    look(5, 5'b01100);
    send(1'b1, 8'h15, 16'h0000);
    look(1, 5'b10100);
    send(1'b1, 8'h01, 16'h0090);
    look(5, 5'b10100);
    complete_run;
  end
endmodule
